/* File: udg_top.sv */
/*
 * Device-level registers and transceiver control of a full-speed USB
 * function. Assumes the controller core runs on I_REF_CLK and the
 * peripheral bus is a simple same-clock strobe bus with one-cycle reads.
 */
`timescale 1ns/1ns
module udg_top (
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    input wire udg_pkg::udg_bus_req_s I_BUS,
    output logic [7:0] O_BUS_RDATA,
    output logic O_BUS_RVALID,
    input wire udg_pkg::udg_core_evt_s I_CORE,
    input wire logic [3:0] I_GS_IF,
    output logic [15:0] O_GS_IF_STATUS,
    output logic [15:0] O_GS_DEV_STATUS,
    output logic [15:0] O_EP_STALL,
    output logic [11:0] O_CFG_REQ,
    output logic [7:0] O_DEV_CTRL,
    output logic O_SETUP_TOK_EN,
    output logic [3:0] O_CHG_CTRL,
    output logic O_SOFT_RESET,
    output logic O_RESUME,
    output logic O_IRQ,
    input wire logic I_TX_DRIVE,
    input wire logic I_TX_DP,
    input wire logic I_TX_DM,
    input wire logic I_DP_IN,
    input wire logic I_DM_IN,
    output logic O_DP_OUT,
    output logic O_DP_OE,
    output logic O_DM_OUT,
    output logic O_DM_OE,
    output logic O_RX_DP,
    output logic O_RX_DM
);
    import udg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    logic [7:0] ep_stall_lo, ep_stall_hi, chg_en, dev_ctrl, pwr_down;
    logic [7:0] dev_irq_en, dev_irq_req, setup_tok, if_sel;
    logic [15:0] dev_gs;
    logic [15:0] if_status [NUM_IF];
    logic [3:0] cfg, ifc, alt;
    logic [10:0] frame;
    logic chg_flag;

    wire in_range = I_BUS.sel && (I_BUS.addr[15:8] == BASE_ADDR[15:8]);
    wire [7:0] ofs = I_BUS.addr[7:0];
    wire wr = in_range && I_BUS.wr;
    wire rd = in_range && I_BUS.rd;
    wire wr_stall_lo = wr && (ofs == OFS_EP_STALL_LO);
    wire wr_stall_hi = wr && (ofs == OFS_EP_STALL_HI);
    wire wr_chg_en = wr && (ofs == OFS_CFG_CHG_EN);
    wire wr_ctrl = wr && (ofs == OFS_DEV_CTRL);
    wire wr_pwr = wr && (ofs == OFS_PWR_DOWN);
    wire wr_irq_en = wr && (ofs == OFS_DEV_IRQ_EN);
    wire wr_gs_lo = wr && (ofs == OFS_DEV_GS_LO);
    wire wr_gs_hi = wr && (ofs == OFS_DEV_GS_HI);
    wire wr_if_lo = wr && (ofs == OFS_IF_GS_LO);
    wire wr_if_hi = wr && (ofs == OFS_IF_GS_HI);
    wire wr_if_sel = wr && (ofs == OFS_IF_SEL);
    wire wr_tok = wr && (ofs == OFS_SETUP_TOK);
    wire rd_irq_req = rd && (ofs == OFS_DEV_IRQ_REQ);
    wire rd_chg_flag = rd && (ofs == OFS_CFG_CHG_FLAG);

    ////////////////////////////////////////////////////////////////////////
    // read-write registers; masks keep reserved bits at zero

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ep_stall_lo <= RST_BYTE;
            ep_stall_hi <= RST_BYTE;
            chg_en <= RST_BYTE;
            dev_ctrl <= RST_BYTE;
            pwr_down <= RST_BYTE;
            dev_irq_en <= RST_BYTE;
            dev_gs <= RST_WORD;
            if_sel <= RST_BYTE;
            setup_tok <= RST_BYTE;
        end else begin
            if (wr_stall_lo) ep_stall_lo <= I_BUS.wdata;
            if (wr_stall_hi) ep_stall_hi <= I_BUS.wdata;
            if (wr_chg_en) chg_en <= I_BUS.wdata & CFG_CHG_EN_MASK;
            if (wr_ctrl) dev_ctrl <= I_BUS.wdata & DEV_CTRL_RW_MASK;
            if (wr_pwr) pwr_down <= I_BUS.wdata & PWR_DOWN_MASK;
            if (wr_irq_en) dev_irq_en <= I_BUS.wdata & DEV_IRQ_MASK;
            if (wr_gs_lo) dev_gs[7:0] <= I_BUS.wdata;
            if (wr_gs_hi) dev_gs[15:8] <= I_BUS.wdata;
            if (wr_if_sel) if_sel <= {4'h0, I_BUS.wdata[3:0]};
            if (wr_tok) setup_tok <= I_BUS.wdata & SETUP_TOK_MASK;
        end
    end

    // command bits: a one pulses for one cycle, a zero does nothing
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_SOFT_RESET <= 1'b0;
            O_RESUME <= 1'b0;
        end else begin
            O_SOFT_RESET <= wr_ctrl && I_BUS.wdata[SWR_BIT];
            O_RESUME <= wr_ctrl && I_BUS.wdata[RSM_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interface status store, one entry per interface, written through
    // the selector so firmware never addresses the array directly

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IF; gi++) begin : g_if
            wire hit = (if_sel[3:0] == 4'(gi));
            always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
                if (!I_RSTN) begin
                    if_status[gi] <= RST_WORD;
                end else begin
                    if (wr_if_lo && hit) if_status[gi][7:0] <= I_BUS.wdata;
                    if (wr_if_hi && hit) if_status[gi][15:8] <= I_BUS.wdata;
                end
            end
        end
    endgenerate

    // Get_Status answers: stored value returned untouched
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_GS_IF_STATUS <= RST_WORD;
            O_GS_DEV_STATUS <= RST_WORD;
        end else begin
            O_GS_IF_STATUS <= if_status[I_GS_IF];
            O_GS_DEV_STATUS <= dev_gs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration request captured from hardware-handled requests

    wire cfg_new = I_CORE.set_cfg && (I_CORE.cfg != cfg);
    wire if_new = I_CORE.set_if && ((I_CORE.ifc != ifc) ||
        (I_CORE.alt != alt));
    wire chg_evt = cfg_new || if_new;

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cfg <= 4'h0;
            ifc <= 4'h0;
            alt <= 4'h0;
        end else begin
            if (I_CORE.set_cfg) cfg <= I_CORE.cfg;
            if (I_CORE.set_if) begin
                ifc <= I_CORE.ifc;
                alt <= I_CORE.alt;
            end
        end
    end

    // change flag clears on read, but a change in the same cycle wins
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) chg_flag <= 1'b0;
        else chg_flag <= (chg_flag && !rd_chg_flag) || chg_evt;
    end

    ////////////////////////////////////////////////////////////////////////
    // line synchronisers and single-ended-zero detection

    logic [1:0] dp_sync, dm_sync;
    logic se0_prev;
    wire se0_now = !dp_sync[1] && !dm_sync[1];
    // synchronisers reset low, which looks like a single-ended zero, so
    // the previous value starts high to keep reset from faking an edge
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            dp_sync <= 2'b00;
            dm_sync <= 2'b00;
            se0_prev <= 1'b1;
        end else begin
            dp_sync <= {dp_sync[0], I_DP_IN};
            dm_sync <= {dm_sync[0], I_DM_IN};
            se0_prev <= se0_now;
        end
    end
    wire se0_evt = se0_now && !se0_prev;

    // device event flags; read clears, a new event in the same cycle wins
    wire [7:0] dev_set = ({se0_evt, I_CORE.dev_evt[6:1], I_CORE.sof} &
        DEV_IRQ_MASK);
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            dev_irq_req <= RST_BYTE;
            frame <= 11'h000;
        end else begin
            dev_irq_req <= (dev_irq_req & ~{8{rd_irq_req}}) | dev_set;
            if (I_CORE.sof) frame <= I_CORE.frame;
        end
    end

    // module interrupt: flags against enables at the same bit positions
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) O_IRQ <= 1'b0;
        else O_IRQ <= (|(dev_irq_req & dev_irq_en)) ||
            (chg_flag && chg_en[CHG_BIT]);
    end

    ////////////////////////////////////////////////////////////////////////
    // transceiver: drivers float while transmit is powered down, and the
    // receive path holds zero while receive is powered down

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_DP_OUT <= 1'b0;
            O_DM_OUT <= 1'b0;
            O_DP_OE <= 1'b0;
            O_DM_OE <= 1'b0;
            O_RX_DP <= 1'b0;
            O_RX_DM <= 1'b0;
        end else begin
            O_DP_OUT <= I_TX_DP;
            O_DM_OUT <= I_TX_DM;
            O_DP_OE <= I_TX_DRIVE && !pwr_down[PWR_TX_BIT];
            O_DM_OE <= I_TX_DRIVE && !pwr_down[PWR_TX_BIT];
            O_RX_DP <= dp_sync[1] && !pwr_down[PWR_RX_BIT];
            O_RX_DM <= dm_sync[1] && !pwr_down[PWR_RX_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; one-cycle latency, unmapped offsets read zero

    logic [7:0] rmux;
    always_comb begin
        case (ofs)
            OFS_EP_STALL_LO: rmux = ep_stall_lo;
            OFS_EP_STALL_HI: rmux = ep_stall_hi;
            OFS_CFG_REQ_LO: rmux = {ifc, alt};
            OFS_CFG_REQ_HI: rmux = {4'h0, cfg};
            OFS_EP_IRQ_LO: rmux = I_CORE.ep_irq[7:0] & EP_IRQ_MASK[7:0];
            OFS_EP_IRQ_HI: rmux = I_CORE.ep_irq[15:8];
            OFS_CFG_CHG_FLAG: rmux = {7'h00, chg_flag};
            OFS_CFG_CHG_EN: rmux = chg_en;
            OFS_DEV_CTRL: rmux = dev_ctrl;
            OFS_PWR_DOWN: rmux = pwr_down;
            OFS_DEV_IRQ_EN: rmux = dev_irq_en;
            OFS_DEV_IRQ_REQ: rmux = dev_irq_req;
            OFS_SETUP_STAT: rmux = {6'h00, I_CORE.setup_stat};
            OFS_FRAME_LO: rmux = frame[7:0];
            OFS_FRAME_HI: rmux = {5'h00, frame[10:8]};
            OFS_DEV_GS_LO: rmux = dev_gs[7:0];
            OFS_DEV_GS_HI: rmux = dev_gs[15:8];
            OFS_IF_GS_LO: rmux = if_status[if_sel[3:0]][7:0];
            OFS_IF_GS_HI: rmux = if_status[if_sel[3:0]][15:8];
            OFS_IF_SEL: rmux = if_sel;
            OFS_SETUP_TOK: rmux = setup_tok;
            OFS_ACTIVE_EP: rmux = {4'h0, I_CORE.active_ep};
            default: rmux = 8'h00;
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_BUS_RDATA <= RST_BYTE;
            O_BUS_RVALID <= 1'b0;
        end else begin
            O_BUS_RDATA <= rd ? rmux : RST_BYTE;
            O_BUS_RVALID <= rd;
        end
    end

    // steering outputs
    assign O_EP_STALL = {ep_stall_hi, ep_stall_lo};
    assign O_CFG_REQ = {cfg, ifc, alt};
    assign O_DEV_CTRL = dev_ctrl;
    assign O_SETUP_TOK_EN = setup_tok[7];
    assign O_CHG_CTRL = chg_en[7:4];

endmodule : udg_top

/* File: udg_pkg.sv */
/*
 * Package of the USB device global register block: register offsets,
 * field positions, reset values and the carrier structs.
 * Assumes one system clock shared with the device controller core.
 */
// How it works
// - transceiver carries 12 Mbit/s full-speed serial traffic
// - separate transmitter and receiver power-down bits
// - power-down tri-states drivers, isolating the port
// - flag single-ended zero when both lines low
// - sixteen 16-bit interface status values for Get_Status
// - return stored interface status whatever its meaning
// - Set_Configuration and Set_Interface handled in hardware
// - read-only config, interface, alternate setting fields
// - config request change sets the change flag
// - change interrupt gated by its enable bit
// - read-only bits ignore writes, read-write bits store
// - command bits act on 1, read 0
// - register addresses are offsets from fixed base
// - each register has unique address; endpoints separate
package udg_pkg;

    // fixed base of the module on the peripheral bus
    localparam logic [15:0] BASE_ADDR = 16'hDD00;
    localparam logic [7:0] OFS_EP_STALL_LO = 8'h01;
    localparam logic [7:0] OFS_EP_STALL_HI = 8'h02;
    localparam logic [7:0] OFS_CFG_REQ_LO = 8'h03;
    localparam logic [7:0] OFS_CFG_REQ_HI = 8'h04;
    localparam logic [7:0] OFS_EP_IRQ_LO = 8'h05;
    localparam logic [7:0] OFS_EP_IRQ_HI = 8'h06;
    localparam logic [7:0] OFS_CFG_CHG_FLAG = 8'h07;
    localparam logic [7:0] OFS_CFG_CHG_EN = 8'h08;
    localparam logic [7:0] OFS_DEV_CTRL = 8'h09;
    localparam logic [7:0] OFS_PWR_DOWN = 8'h0A;
    localparam logic [7:0] OFS_DEV_IRQ_EN = 8'h0B;
    localparam logic [7:0] OFS_DEV_IRQ_REQ = 8'h0C;
    localparam logic [7:0] OFS_SETUP_STAT = 8'h0D;
    localparam logic [7:0] OFS_FRAME_LO = 8'h0E;
    localparam logic [7:0] OFS_FRAME_HI = 8'h0F;
    localparam logic [7:0] OFS_DEV_GS_LO = 8'h10;
    localparam logic [7:0] OFS_DEV_GS_HI = 8'h11;
    localparam logic [7:0] OFS_IF_GS_LO = 8'h12;
    localparam logic [7:0] OFS_IF_GS_HI = 8'h13;
    localparam logic [7:0] OFS_IF_SEL = 8'h14;
    localparam logic [7:0] OFS_SETUP_TOK = 8'h15;
    localparam logic [7:0] OFS_ACTIVE_EP = 8'h16;

    // writable masks: bits outside read back as zero
    localparam logic [7:0] CFG_CHG_EN_MASK = 8'hF1;
    localparam logic [7:0] DEV_CTRL_RW_MASK = 8'h1A;
    localparam logic [7:0] DEV_CTRL_CMD_MASK = 8'h24;
    localparam logic [7:0] PWR_DOWN_MASK = 8'h03;
    localparam logic [7:0] DEV_IRQ_MASK = 8'hDF;
    localparam logic [7:0] SETUP_TOK_MASK = 8'h80;
    localparam logic [15:0] EP_IRQ_MASK = 16'hFFE1;
    // field positions
    localparam int PWR_RX_BIT = 0;
    localparam int PWR_TX_BIT = 1;
    localparam int SE0_BIT = 7;
    localparam int SOF_BIT = 0;
    localparam int CHG_BIT = 0;
    localparam int SWR_BIT = 5;
    localparam int RSM_BIT = 2;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam int NUM_IF = 16;
    // full-speed bit time in ns and cycles of the 125 MHz clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int FS_BIT_NS = 83;
    localparam int FS_BIT_CYCLES = FS_BIT_NS / CLK_PERIOD_NS;

    // one peripheral bus access
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } udg_bus_req_s;

    // events from the device controller core
    typedef struct packed {
        logic set_cfg;
        logic [3:0] cfg;
        logic set_if;
        logic [3:0] ifc;
        logic [3:0] alt;
        logic sof;
        logic [10:0] frame;
        logic [7:0] dev_evt;
        logic [1:0] setup_stat;
        logic [3:0] active_ep;
        logic [15:0] ep_irq;
    } udg_core_evt_s;

endpackage : udg_pkg

/* File: udg_top_sva.sv */
/* checker of the udg_top port behaviour.
   assumes a bind from the bench, one clock and async active low reset. */
`timescale 1ns/1ns
module udg_top_sva (
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    input wire udg_pkg::udg_bus_req_s I_BUS,
    input wire udg_pkg::udg_core_evt_s I_CORE,
    input wire logic I_TX_DRIVE,
    input wire logic [7:0] O_BUS_RDATA,
    input wire logic O_BUS_RVALID,
    input wire logic [11:0] O_CFG_REQ,
    input wire logic [7:0] O_DEV_CTRL,
    input wire logic O_SOFT_RESET,
    input wire logic O_DP_OE,
    input wire logic O_DM_OE
);
    import udg_pkg::*;
    ////////////////////////////////////////
    // decode of the accesses the rules talk about
    localparam logic [15:0] CTRL_ADDR = BASE_ADDR | 16'(OFS_DEV_CTRL);
    wire logic hit = I_BUS.sel && I_BUS.addr[15:8] == BASE_ADDR[15:8];
    wire logic ctrl_wr = I_BUS.sel && I_BUS.wr && I_BUS.addr == CTRL_ADDR;
    wire logic soft_req = ctrl_wr && I_BUS.wdata[SWR_BIT];
    default clocking @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RSTN);
    ////////////////////////////////////////
    // bus answer
    sequence s_read;
        hit && I_BUS.rd;
    endsequence
    a_read_answer: assert property (s_read |=> O_BUS_RVALID)
        else $error("read not answered");
    a_idle_zero: assert property (!O_BUS_RVALID |-> O_BUS_RDATA == 8'h00)
        else $error("read data not zero");
    // hardware handled requests
    a_cfg_load: assert property (I_CORE.set_cfg |=>
        O_CFG_REQ[11:8] == $past(I_CORE.cfg)) else $error("cfg not taken");
    a_if_load: assert property (I_CORE.set_if |=>
        O_CFG_REQ[7:0] == {$past(I_CORE.ifc), $past(I_CORE.alt)})
        else $error("interface not taken");
    a_cfg_hold: assert property (!I_CORE.set_cfg && !I_CORE.set_if |=>
        $stable(O_CFG_REQ)) else $error("cfg moved alone");
    // control register and command bits
    a_ctrl_store: assert property (ctrl_wr |=>
        O_DEV_CTRL == ($past(I_BUS.wdata) & DEV_CTRL_RW_MASK))
        else $error("control bits not stored");
    a_soft_pulse: assert property (soft_req |=> O_SOFT_RESET)
        else $error("command not issued");
    a_soft_cause: assert property (O_SOFT_RESET |-> $past(soft_req))
        else $error("command without write");
    // driver enables move together and only for transmit
    a_oe_pair: assert property (O_DP_OE == O_DM_OE)
        else $error("enables differ");
    a_oe_cause: assert property (O_DP_OE |-> $past(I_TX_DRIVE))
        else $error("driving without transmit");
endmodule : udg_top_sva

/* File: udg_host_line.sv */
/* host end of the full-speed cable.
   assumes SE0 requests come while the device is not driving. */
`timescale 1ns/1ns
module udg_host_line (
    input wire logic i_se0,
    input wire logic i_dp_out,
    input wire logic i_dp_oe,
    input wire logic i_dm_out,
    input wire logic i_dm_oe,
    output logic o_dp,
    output logic o_dm
);
    // released lines settle to pull-up J, so no stale value survives
    assign o_dp = i_dp_oe ? i_dp_out : !i_se0;
    assign o_dm = i_dm_oe && i_dm_out;
endmodule : udg_host_line

/* File: udg_top_bench.sv */
/* self-checking bench of udg_top with a host line model.
   assumes the strobe bus and one-cycle read answer of the design. */
`timescale 1ns/1ns
module udg_top_bench;
    import udg_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    udg_bus_req_s bus = '0;
    udg_core_evt_s core = '0;
    logic [3:0] gs_if = 4'h0;
    logic tx_drive = 1'b0;
    logic se0 = 1'b0;
    logic [7:0] base_hi = 8'hDD;
    logic [7:0] rdata, dev_ctrl;
    logic [15:0] gs_status, ep_stall, gs_dev;
    logic [3:0] chg_ctrl;
    logic tok_en;
    logic [11:0] cfg_req;
    logic rvalid, soft_reset, resume, irq, dp, dm;
    logic dp_out, dp_oe, dm_out, dm_oe, rx_dp, rx_dm;
    int fail_count = 0;
    int checks = 0;
    logic [7:0] ofs [20] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
        8'h10, 8'h11, 8'h14, 8'h15, 8'h16};
    logic [7:0] msk [20] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hF1, 8'h1A, 8'h03, 8'hDF, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hFF, 8'hFF, 8'h0F, 8'h80, 8'h00};
    ////////////////////////////////////////
    always #4 clk = !clk;
    udg_top u_udg_top (.I_REF_CLK(clk), .I_RSTN(rstn), .I_BUS(bus),
        .O_BUS_RDATA(rdata), .O_BUS_RVALID(rvalid), .I_CORE(core),
        .I_GS_IF(gs_if), .O_GS_IF_STATUS(gs_status),
        .O_GS_DEV_STATUS(gs_dev),
        .O_EP_STALL(ep_stall), .O_CFG_REQ(cfg_req), .O_DEV_CTRL(dev_ctrl),
        .O_SETUP_TOK_EN(tok_en), .O_CHG_CTRL(chg_ctrl),
        .O_SOFT_RESET(soft_reset),
        .O_RESUME(resume), .O_IRQ(irq), .I_TX_DRIVE(tx_drive),
        .I_TX_DP(1'b0), .I_TX_DM(1'b1), .I_DP_IN(dp), .I_DM_IN(dm),
        .O_DP_OUT(dp_out), .O_DP_OE(dp_oe), .O_DM_OUT(dm_out),
        .O_DM_OE(dm_oe), .O_RX_DP(rx_dp), .O_RX_DM(rx_dm));
    udg_host_line u_udg_host_line (.i_se0(se0), .i_dp_out(dp_out),
        .i_dp_oe(dp_oe), .i_dm_out(dm_out), .i_dm_oe(dm_oe),
        .o_dp(dp), .o_dm(dm));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // strobe held exactly one edge, then a gap cycle before the next access
    task automatic acc(input logic w, input logic [7:0] o,
        input logic [7:0] d);
        @(posedge clk);
        bus <= '{sel: 1'b1, wr: w, rd: !w, addr: {base_hi, o}, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : acc
    task automatic ro(input logic [7:0] o, input logic [7:0] e);
        acc(1'b0, o, 8'h00);
        chk({8'h00, rvalid === 1'b1 ? rdata : 8'hXX}, {8'h00, e});
    endtask : ro
    task automatic pulse(input logic cf, input logic [3:0] c,
        input logic [7:0] ia);
        @(posedge clk);
        core.set_cfg <= cf;
        core.set_if <= !cf;
        core.cfg <= c;
        core.ifc <= ia[7:4];
        core.alt <= ia[3:0];
        @(posedge clk);
        core.set_cfg <= 1'b0;
        core.set_if <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    task automatic report_and_stop;
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////
    // watchdog well above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 20; i++) ro(ofs[i], 8'h00);
        acc(1'b1, OFS_DEV_CTRL, 8'h20);
        chk(16'(soft_reset), 16'h0001);
        ro(OFS_DEV_CTRL, 8'h00);
        acc(1'b1, OFS_DEV_CTRL, 8'h04);
        chk(16'(resume), 16'h0001);
        // every offset but the interface status pair: written bits stored, read-only bits unmoved
        for (int i = 0; i < 20; i++) begin
            acc(1'b1, ofs[i], 8'hDF);
            ro(ofs[i], 8'hDF & msk[i]);
        end
        chk(ep_stall, 16'hDFDF);
        chk({8'h00, dev_ctrl}, 16'h001A);
        chk(gs_dev, 16'hDFDF);
        chk({15'h0, tok_en}, 16'h0001);
        chk({12'h0, chg_ctrl}, 16'h000D);
        for (int i = 0; i < 20; i++) acc(1'b1, ofs[i], 8'h00);
        base_hi = 8'hDE;
        acc(1'b1, OFS_EP_STALL_LO, 8'h5A);
        base_hi = 8'hDD;
        ro(OFS_EP_STALL_LO, 8'h00);
        acc(1'b1, 8'h17, 8'h5A);
        ro(8'h17, 8'h00);
        @(posedge clk);
        core.ep_irq <= 16'hFFFF;
        core.active_ep <= 4'hA;
        core.setup_stat <= 2'h3;
        ro(OFS_EP_IRQ_LO, 8'hE1);
        ro(OFS_EP_IRQ_HI, 8'hFF);
        ro(OFS_ACTIVE_EP, 8'h0A);
        ro(OFS_SETUP_STAT, 8'h03);
        // select first, then load the status pair of each interface
        for (int i = 0; i < 16; i++) begin
            acc(1'b1, OFS_IF_SEL, 8'(i));
            acc(1'b1, OFS_IF_GS_LO, 8'(i * 17));
            acc(1'b1, OFS_IF_GS_HI, 8'(240 - i));
        end
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            gs_if <= 4'(i);
            repeat (2) @(posedge clk);
            #1 chk(gs_status, {8'(240 - i), 8'(i * 17)});
        end
        acc(1'b1, OFS_IF_SEL, 8'h07);
        ro(OFS_IF_GS_LO, 8'h77);
        ro(OFS_IF_GS_HI, 8'hE9);
        acc(1'b1, OFS_CFG_CHG_EN, 8'h01);
        pulse(1'b1, 4'h5, 8'h00);
        chk(16'(irq), 16'h0001);
        ro(OFS_CFG_REQ_HI, 8'h05);
        ro(OFS_CFG_CHG_FLAG, 8'h01);
        ro(OFS_CFG_CHG_FLAG, 8'h00);
        pulse(1'b1, 4'h5, 8'h00);
        ro(OFS_CFG_CHG_FLAG, 8'h00);
        acc(1'b1, OFS_CFG_CHG_EN, 8'h00);
        pulse(1'b0, 4'h0, 8'h32);
        chk(16'(irq), 16'h0000);
        chk({4'h0, cfg_req}, 16'h0532);
        ro(OFS_CFG_CHG_FLAG, 8'h01);
        acc(1'b1, OFS_DEV_IRQ_EN, 8'h80);
        @(posedge clk);
        core.sof <= 1'b1;
        core.frame <= 11'h5A5;
        @(posedge clk);
        core.sof <= 1'b0;
        ro(OFS_FRAME_LO, 8'hA5);
        ro(OFS_FRAME_HI, 8'h05);
        chk(16'(irq), 16'h0000);
        ro(OFS_DEV_IRQ_REQ, 8'h01);
        @(posedge clk);
        se0 <= 1'b1;
        repeat (8) @(posedge clk);
        se0 <= 1'b0;
        #1 chk(16'(irq), 16'h0001);
        ro(OFS_DEV_IRQ_REQ, 8'h80);
        @(posedge clk);
        core.dev_evt <= 8'h7E;
        @(posedge clk);
        core.dev_evt <= 8'h00;
        #1 chk(16'(irq), 16'h0000);
        ro(OFS_DEV_IRQ_REQ, 8'h5E);
        // transmit path, then each power-down bit on its own
        @(posedge clk);
        tx_drive <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({12'h0, dp_oe, dm_oe, dp_out, dm_out}, 16'h000D);
        acc(1'b1, OFS_PWR_DOWN, 8'h02);
        @(posedge clk);
        #1 chk({14'h0, dp_oe, dm_oe}, 16'h0000);
        @(posedge clk);
        tx_drive <= 1'b0;
        acc(1'b1, OFS_PWR_DOWN, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk({14'h0, rx_dp, rx_dm}, 16'h0002);
        acc(1'b1, OFS_PWR_DOWN, 8'h01);
        @(posedge clk);
        #1 chk({14'h0, rx_dp, rx_dm}, 16'h0000);
        report_and_stop();
    end
endmodule : udg_top_bench
bind udg_top udg_top_sva u_udg_top_sva (.I_REF_CLK(I_REF_CLK),
    .I_RSTN(I_RSTN), .I_BUS(I_BUS), .I_CORE(I_CORE),
    .I_TX_DRIVE(I_TX_DRIVE), .O_BUS_RDATA(O_BUS_RDATA),
    .O_BUS_RVALID(O_BUS_RVALID), .O_CFG_REQ(O_CFG_REQ),
    .O_DEV_CTRL(O_DEV_CTRL), .O_SOFT_RESET(O_SOFT_RESET),
    .O_DP_OE(O_DP_OE), .O_DM_OE(O_DM_OE));
